// file: dv/bridge_window_regs_chk.sv
module bridge_window_regs_chk
  import bridge_regs_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic        i_downstream_system_error_in_n,
  input wire logic        i_master_abort_received,
  input wire logic        i_parity_error_detected,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr
);
  // ----
  // Port checks
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic rd_st;
  logic mapped;
  assign rd_st  = o_pready && i_psel && !i_pwrite
                  && i_paddr == ADDR_IO_AND_STATUS;
  assign mapped = i_paddr inside {ADDR_IO_AND_STATUS, ADDR_MEMORY_WINDOW,
    ADDR_IO_UPPER, ADDR_CONTROL, ADDR_IRQ_MASK, ADDR_PROBE,
    ADDR_PROBE_RESULT};
  sequence s_access_done;
    i_penable && !o_pready ##1 o_pready;
  endsequence
  // Flag read two cycles after its cause, set wins over any clear
  property p_flag(logic ev, int b);
    (rd_st && $past(ev, 2)) |-> o_prdata[b];
  endproperty
  a_ready_follows: assert property (i_psel && !i_penable |=> s_access_done)
    else $error("pready late");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ready_has_req: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("pready without request");
  a_err_decode: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("pslverr wrong");
  a_status_const: assert property (
    rd_st |-> o_prdata[11:8] == IO_WIDTH_CODE
    && o_prdata[26:25] == CLAIM_MEDIUM && o_prdata[23:16] == 8'ha0)
    else $error("status constant bits wrong");
  a_mem_low_zero: assert property (
    o_pready && i_psel && !i_pwrite
    && i_paddr == ADDR_MEMORY_WINDOW |-> o_prdata[19:16] == 4'h0
    && o_prdata[3:0] == 4'h0)
    else $error("memory low bits not zero");
  a_sys_err_flag: assert property (
    p_flag(!i_downstream_system_error_in_n, 30))
    else $error("system error flag missing");
  a_mabort_flag: assert property (p_flag(i_master_abort_received, 29))
    else $error("master abort flag missing");
  a_parity_flag: assert property (p_flag(i_parity_error_detected, 31))
    else $error("parity flag missing");
endmodule : bridge_window_regs_chk

bind bridge_window_regs bridge_window_regs_chk chk (.*);

// file: dv/bridge_window_regs_tb.sv
module bridge_window_regs_tb;
  import bridge_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_reset_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [31:0] exp_st;
  logic [3:0] i_pstrb = 4'h0;
  logic [5:0] ev = 6'h00;
  logic pe_n, se_n, ta_s, ta_r, ma_r, pd, o_pready, o_pslverr, o_irq, err;
  logic o_io_hit, o_mem_hit;
  int num_errors = 0, check_count = 0;
  int pos[6] = '{24, 27, 28, 29, 30, 31};
  localparam logic [31:0] ST = 32'h02a0_f100;
  always #20 i_clk = ~i_clk;
  bridge_window_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .i_downstream_parity_error_in_n(pe_n),
    .i_downstream_system_error_in_n(se_n),
    .i_target_abort_signaled(ta_s), .i_target_abort_received(ta_r),
    .i_master_abort_received(ma_r), .i_parity_error_detected(pd),
    .i_probe_addr(32'h0), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_irq(o_irq), .o_io_hit(o_io_hit),
    .o_mem_hit(o_mem_hit));
  downstream_events_model far (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_fire(ev), .o_parity_error_n(pe_n), .o_system_error_n(se_n),
    .o_abort_signaled(ta_s), .o_abort_received(ta_r),
    .o_master_abort(ma_r), .o_parity_seen(pd));
  // ----
  // Bus and compare tasks
  // ----
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_paddr   <= a;
    i_pwrite  <= w;
    i_pwdata  <= d;
    i_pstrb   <= w ? 4'hf : 4'h0;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) begin
      @(posedge i_clk);
    end
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : xfer
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(rd, e);
  endtask : rd_chk
  task fire(input int b);
    @(posedge i_clk);
    ev <= 6'(1 << b);
    @(posedge i_clk);
    ev <= 6'h0;
    repeat (2) @(posedge i_clk);
  endtask : fire
  // Hit flags settle one cycle after the probe write lands; the read covers it
  task probe(input logic [31:0] a, input logic [1:0] e);
    xfer(ADDR_PROBE, 1'b1, a);
    rd_chk(ADDR_PROBE_RESULT, {30'h0, e});
    check({30'h0, o_mem_hit, o_io_hit}, {30'h0, e});
  endtask : probe
  task give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd_chk(ADDR_IO_AND_STATUS, 32'h02a0_0100);
    rd_chk(ADDR_MEMORY_WINDOW, 32'h0);
    rd_chk(8'h50, 32'h0);
    check(32'(err), 32'h1);
    $display("test reset values done");
    xfer(ADDR_IO_AND_STATUS, 1'b1, 32'h0000_ffff);
    rd_chk(8'h1c, ST);
    xfer(ADDR_MEMORY_WINDOW, 1'b1, 32'hffff_ffff);
    rd_chk(ADDR_MEMORY_WINDOW, 32'hfff0_fff0);
    $display("test field access done");
    xfer(ADDR_CONTROL, 1'b1, 32'h40);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'hff);
    for (int i = 0; i < 6; i++) begin
      fire(i);
      exp_st = ST | (32'h1 << pos[i]);
      rd_chk(8'h1c, exp_st);
      check(32'(o_irq), 32'h1);
      xfer(8'h1c, 1'b1, 32'h0000_f000);
      rd_chk(8'h1c, exp_st);
      xfer(8'h1c, 1'b1, 32'hff00_f000);
      rd_chk(8'h1c, ST);
      check(32'(o_irq), 32'h0);
    end
    xfer(ADDR_CONTROL, 1'b1, 32'h0);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h0);
    fire(0);
    fire(4);
    rd_chk(8'h1c, ST | 32'h4000_0000);
    check(32'(o_irq), 32'h0);
    // System error reaches the flag on the very edge that completes
    // the clear, so only a set that beats the clear keeps bit 30
    fork
      xfer(8'h1c, 1'b1, 32'hff00_f000);
      begin
        repeat (2) @(posedge i_clk);
        ev <= 6'h10;
        @(posedge i_clk);
        ev <= 6'h00;
      end
    join
    rd_chk(8'h1c, ST | 32'h4000_0000);
    fire(0);
    xfer(8'h1c, 1'b1, 32'hff00_f000);
    rd_chk(8'h1c, ST);
    $display("test status flags done");
    // I/O base sits at zero here, so only the top bound is exercised
    xfer(8'h1c, 1'b1, 32'h0000_3000);
    xfer(ADDR_MEMORY_WINDOW, 1'b1, 32'h1000_1000);
    probe(32'h0000_3fff, 2'b01);
    probe(32'h0000_4000, 2'b00);
    probe(32'h0fff_ffff, 2'b00);
    probe(32'h1000_0000, 2'b10);
    probe(32'h100f_ffff, 2'b10);
    probe(32'h1010_0000, 2'b00);
    xfer(ADDR_IO_UPPER, 1'b1, 32'h0001_0000);
    probe(32'h0001_3fff, 2'b01);
    probe(32'h0001_4000, 2'b00);
    $display("test windows done");
    give_verdict();
  end
endmodule : bridge_window_regs_tb

// file: dv/downstream_events_model.sv
module downstream_events_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [5:0] i_fire,
  output logic            o_parity_error_n,
  output logic            o_system_error_n,
  output logic            o_abort_signaled,
  output logic            o_abort_received,
  output logic            o_master_abort,
  output logic            o_parity_seen
);
  // ----
  // Secondary bus events, one cycle per request
  // ----
  // Error lines idle high, as pulled up on the bus
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {o_parity_error_n, o_system_error_n} <= 2'h3;
      {o_abort_signaled, o_abort_received} <= 2'h0;
      {o_master_abort, o_parity_seen}      <= 2'h0;
    end else begin
      o_parity_error_n <= !i_fire[0];
      o_abort_signaled <= i_fire[1];
      o_abort_received <= i_fire[2];
      o_master_abort   <= i_fire[3];
      o_system_error_n <= !i_fire[4];
      o_parity_seen    <= i_fire[5];
    end
  end
endmodule : downstream_events_model

// file: verilog/bridge_regs_pkg.sv
package bridge_regs_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_IO_AND_STATUS  = 8'h1c;
  localparam logic [7:0] ADDR_MEMORY_WINDOW  = 8'h20;
  localparam logic [7:0] ADDR_IO_UPPER       = 8'h30;
  localparam logic [7:0] ADDR_CONTROL        = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h44;
  localparam logic [7:0] ADDR_PROBE          = 8'h48;
  localparam logic [7:0] ADDR_PROBE_RESULT   = 8'h4c;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int IO_TOP_LSB        = 12;
  localparam int IO_WIDTH_LSB      = 8;
  localparam int IO_LOW_BITS       = 12;
  localparam int FAST_66_BIT       = 21;
  localparam int FAST_B2B_BIT      = 23;
  localparam int CLAIM_TIMING_LSB  = 25;
  localparam int FLAG_PARITY_RPT   = 24;
  localparam int FLAG_SIG_TABORT   = 27;
  localparam int FLAG_RCV_TABORT   = 28;
  localparam int FLAG_RCV_MABORT   = 29;
  localparam int FLAG_SYS_ERROR    = 30;
  localparam int FLAG_PARITY_SEEN  = 31;
  localparam int FLAG_LSB          = 24;
  localparam int MEM_BOTTOM_LSB    = 4;
  localparam int MEM_TOP_LSB       = 20;
  localparam int MEM_LOW_BITS      = 20;
  localparam int PARITY_RESP_BIT   = 6;

  // ------------------------------------------------------------------
  // Constant field values and reset values
  // ------------------------------------------------------------------
  localparam logic [3:0]  IO_WIDTH_CODE    = 4'h1;
  localparam logic [1:0]  CLAIM_FAST       = 2'h0;
  localparam logic [1:0]  CLAIM_MEDIUM     = 2'h1;
  localparam logic [1:0]  CLAIM_SLOW       = 2'h2;
  localparam logic [7:0]  FLAG_WC_MASK     = 8'hf9;
  localparam logic [3:0]  IO_TOP_RESET     = 4'h0;
  localparam logic [11:0] MEM_RESET        = 12'h000;
  localparam logic [15:0] IO_UPPER_RESET   = 16'h0000;
  localparam logic [7:0]  FLAG_RESET       = 8'h00;
  localparam logic [15:0] CONTROL_RESET    = 16'h0000;

endpackage : bridge_regs_pkg

// file: verilog/bridge_window_regs.sv
// Summary of operation
// - I/O window top bits 15:12 writable at register bits 15:12, reset zero.
// - I/O top low twelve address bits compare as all ones.
// - Bits 11:8 read constant one, 32-bit I/O addressing.
// - I/O top bits 31:16 come from the separate upper-half register.
// - Status bit 21 reads one: 66 MHz capable.
// - Status bit 23 reads one: fast back-to-back capable.
// - Bit 24 sets on parity-error input while command bit 6 set.
// - Bits 26:25 read the medium claim timing code 01.
// - Bit 27 sets when bridge as target signals target abort.
// - Bit 28 sets when bridge-mastered transfer receives target abort.
// - Bit 29 sets when bridge-mastered transfer ends in master abort.
// - Bit 30 sets on system-error input.
// - Bit 31 sets on any secondary parity error, regardless of enable.
// - Memory bottom bits 15:4 give address 31:20, low bits zero.
// - Memory bottom bits 3:0 and top bits 19:16 read zero.
// - Memory top bits 31:20 give address 31:20, low bits all ones.
//
// The APB slave port is this design's own decision.
module bridge_window_regs
  import bridge_regs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  input  wire logic        i_downstream_parity_error_in_n,
  input  wire logic        i_downstream_system_error_in_n,
  input  wire logic        i_target_abort_signaled,
  input  wire logic        i_target_abort_received,
  input  wire logic        i_master_abort_received,
  input  wire logic        i_parity_error_detected,
  input  wire logic [31:0] i_probe_addr,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  output logic             o_io_hit,
  output logic             o_mem_hit
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [3:0]  io_top;
  logic [15:0] io_top_upper;
  logic [11:0] mem_bottom;
  logic [11:0] mem_top;
  logic [15:0] control;
  logic [7:0]  irq_mask;
  logic [31:0] probe_addr;
  logic [3:0]  next_io_top;
  logic [15:0] next_io_top_upper;
  logic [11:0] next_mem_bottom;
  logic [11:0] next_mem_top;
  logic [15:0] next_control;
  logic [7:0]  next_irq_mask;
  logic [31:0] next_probe_addr;

  logic        access;
  logic        wr;
  logic        done;
  logic        known;
  logic        lane_io_top;
  logic        lane_mem_bottom;
  logic        lane_mem_top;
  logic        lane_io_upper;
  logic        lane_flags;
  logic [31:0] wmask;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clear;
  logic [7:0]  flags;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq;
  logic        next_io_hit;
  logic        next_mem_hit;
  logic [31:0] io_bottom_addr;
  logic [31:0] io_top_addr;
  logic [31:0] mem_bottom_addr;
  logic [31:0] mem_top_addr;
  logic        io_match;
  logic        mem_match;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Slave answers in the second access cycle, so pready is high for
  // one cycle per transfer and the master always waits one cycle.
  assign access = i_psel && i_penable && !o_pready;
  // Writes land on the completing edge, where the master sees pready;
  // a transfer still in its first access cycle changes nothing yet.
  assign done   = i_psel && i_penable && o_pready;
  assign wr     = done && i_pwrite;
  assign known  = (i_paddr == ADDR_IO_AND_STATUS) ||
                  (i_paddr == ADDR_MEMORY_WINDOW) ||
                  (i_paddr == ADDR_IO_UPPER) ||
                  (i_paddr == ADDR_CONTROL) ||
                  (i_paddr == ADDR_IRQ_MASK) ||
                  (i_paddr == ADDR_PROBE) ||
                  (i_paddr == ADDR_PROBE_RESULT);
  assign wmask  = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                   {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

  // ------------------------------------------------------------------
  // Byte lane qualifiers
  // ------------------------------------------------------------------
  // A bound split over two lanes moves only when both lanes are written,
  // so a half-written window bound never reaches the decode.
  assign lane_io_top     = i_pstrb[1];
  assign lane_mem_bottom = i_pstrb[0] && i_pstrb[1];
  assign lane_mem_top    = i_pstrb[2] && i_pstrb[3];
  assign lane_io_upper   = i_pstrb[2] && i_pstrb[3];
  assign lane_flags      = i_pstrb[3];

  // ------------------------------------------------------------------
  // Writable fields
  // ------------------------------------------------------------------
  always_comb begin
    next_io_top       = io_top;
    next_io_top_upper = io_top_upper;
    next_mem_bottom   = mem_bottom;
    next_mem_top      = mem_top;
    next_control      = control;
    next_irq_mask     = irq_mask;
    next_probe_addr   = probe_addr;
    if (wr) begin
      case (i_paddr)
        ADDR_IO_AND_STATUS: begin
          if (lane_io_top) begin
            next_io_top = i_pwdata[IO_TOP_LSB +: 4];
          end
        end
        ADDR_MEMORY_WINDOW: begin
          if (lane_mem_bottom) begin
            next_mem_bottom = i_pwdata[MEM_BOTTOM_LSB +: 12];
          end
          if (lane_mem_top) begin
            next_mem_top = i_pwdata[MEM_TOP_LSB +: 12];
          end
        end
        ADDR_IO_UPPER: begin
          if (lane_io_upper) begin
            next_io_top_upper = i_pwdata[31:16];
          end
        end
        ADDR_CONTROL: begin
          next_control = (control & ~wmask[15:0]) |
                         (i_pwdata[15:0] & wmask[15:0]);
        end
        ADDR_IRQ_MASK: begin
          if (i_pstrb[0]) begin
            next_irq_mask = i_pwdata[7:0];
          end
        end
        ADDR_PROBE: begin
          next_probe_addr = (probe_addr & ~wmask) | (i_pwdata & wmask);
        end
        default: begin
          next_probe_addr = probe_addr;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      io_top       <= IO_TOP_RESET;
      io_top_upper <= IO_UPPER_RESET;
      mem_bottom   <= MEM_RESET;
      mem_top      <= MEM_RESET;
      control      <= CONTROL_RESET;
      irq_mask     <= FLAG_RESET;
      probe_addr   <= '0;
    end else begin
      io_top       <= next_io_top;
      io_top_upper <= next_io_top_upper;
      mem_bottom   <= next_mem_bottom;
      mem_top      <= next_mem_top;
      control      <= next_control;
      irq_mask     <= next_irq_mask;
      probe_addr   <= next_probe_addr;
    end
  end

  // ------------------------------------------------------------------
  // Error flags, status bits 31:24
  // ------------------------------------------------------------------
  // Level inputs keep setting the flag while they stay asserted
  always_comb begin
    flag_set = '0;
    flag_set[FLAG_PARITY_RPT - FLAG_LSB] =
      !i_downstream_parity_error_in_n && control[PARITY_RESP_BIT];
    flag_set[FLAG_SIG_TABORT - FLAG_LSB] = i_target_abort_signaled;
    flag_set[FLAG_RCV_TABORT - FLAG_LSB] = i_target_abort_received;
    flag_set[FLAG_RCV_MABORT - FLAG_LSB] = i_master_abort_received;
    flag_set[FLAG_SYS_ERROR - FLAG_LSB] =
      !i_downstream_system_error_in_n;
    flag_set[FLAG_PARITY_SEEN - FLAG_LSB] =
      i_parity_error_detected;
  end

  // Write one to clear; only the flag lanes respond
  assign flag_clear = (wr && i_paddr == ADDR_IO_AND_STATUS && lane_flags)
                      ? (i_pwdata[31:24] & FLAG_WC_MASK) : 8'h00;

  // Flag bits 1 and 2 (status bits 26:25) hold the fixed claim timing code, not flags
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      if (FLAG_WC_MASK[g]) begin : g_live
        sticky_flag u_flag (
          .i_clk     (i_clk),
          .i_reset_n (i_reset_n),
          .i_set     (flag_set[g]),
          .i_clear   (flag_clear[g]),
          .o_flag    (flags[g])
        );
      end else begin : g_fixed
        assign flags[g] = 1'b0;
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[IO_TOP_LSB +: 4]       = io_top;
    status_word[IO_WIDTH_LSB +: 4]     = IO_WIDTH_CODE;
    status_word[FAST_66_BIT]           = 1'b1;
    status_word[FAST_B2B_BIT]          = 1'b1;
    status_word[FLAG_LSB +: 8]         = flags;
    status_word[CLAIM_TIMING_LSB +: 2] = CLAIM_MEDIUM;
  end

  always_comb begin
    case (i_paddr)
      ADDR_IO_AND_STATUS: read_word = status_word;
      ADDR_MEMORY_WINDOW: read_word = {mem_top, 4'h0,
                                       mem_bottom, 4'h0};
      ADDR_IO_UPPER:      read_word = {io_top_upper, 16'h0000};
      ADDR_CONTROL:       read_word = {16'h0000, control};
      ADDR_IRQ_MASK:      read_word = {24'h000000, irq_mask};
      ADDR_PROBE:         read_word = probe_addr;
      ADDR_PROBE_RESULT:  read_word = {30'h00000000, o_mem_hit, o_io_hit};
      default:            read_word = 32'h00000000;
    endcase
  end

  // Read data are registered in the first access cycle and stand
  // until the next read, so the master may take them on its own edge.
  always_comb begin
    next_pready  = access;
    next_pslverr = access && !known;
    next_prdata  = o_prdata;
    if (access && !i_pwrite) begin
      next_prdata = read_word;
    end
  end

  // ------------------------------------------------------------------
  // Window decode
  // ------------------------------------------------------------------
  // The I/O bottom lives outside this bank; zero keeps the I/O window
  // reaching from address 0 up to the programmed top.
  assign io_bottom_addr  = 32'h00000000;
  assign io_top_addr     = {io_top_upper, io_top,
                            {IO_LOW_BITS{1'b1}}};
  assign mem_bottom_addr = {mem_bottom, {MEM_LOW_BITS{1'b0}}};
  assign mem_top_addr    = {mem_top, {MEM_LOW_BITS{1'b1}}};

  window_match u_io_match (
    .i_bottom (io_bottom_addr),
    .i_top    (io_top_addr),
    .i_addr   (probe_addr),
    .o_hit    (io_match)
  );

  window_match u_mem_match (
    .i_bottom (mem_bottom_addr),
    .i_top    (mem_top_addr),
    .i_addr   (probe_addr),
    .o_hit    (mem_match)
  );

  // ------------------------------------------------------------------
  // Bus answer registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt and window hit registers
  // ------------------------------------------------------------------
  // Masked flags still latch; the mask only gates the request line
  always_comb begin
    next_irq     = |(flags & irq_mask);
    next_io_hit  = io_match;
    next_mem_hit = mem_match;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq     <= 1'b0;
      o_io_hit  <= 1'b0;
      o_mem_hit <= 1'b0;
    end else begin
      o_irq     <= next_irq;
      o_io_hit  <= next_io_hit;
      o_mem_hit <= next_mem_hit;
    end
  end

  // i_probe_addr is unused: software programs the probe address
  logic unused_probe;
  assign unused_probe = ^i_probe_addr;

endmodule : bridge_window_regs

// file: verilog/sticky_flag.sv
module sticky_flag
  import bridge_regs_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  logic next_flag;

  // Set beats clear in the same cycle so no event is lost
  always_comb begin
    next_flag = o_flag;
    if (i_clear) begin
      next_flag = 1'b0;
    end
    if (i_set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule : sticky_flag

// file: verilog/window_match.sv
module window_match
  import bridge_regs_pkg::*;
(
  input  wire logic [31:0] i_bottom,
  input  wire logic [31:0] i_top,
  input  wire logic [31:0] i_addr,
  output logic             o_hit
);

  // Both ends of the window are inclusive
  assign o_hit = (i_addr >= i_bottom) && (i_addr <= i_top);

endmodule : window_match
